// file: ppo_pkg.sv
// Package for the peak power and overcurrent options register.
// Assumes a 50 MHz sys_clk and a byte-wide register access port.
package ppo_pkg;

    // Register indices, reset value
    localparam logic [7:0] PPO_IDX_LOW = 8'h32;
    localparam logic [7:0] PPO_IDX_HIGH = 8'h33;
    localparam logic [15:0] PPO_RESET = 16'h02b7;

    // Field positions in the 16-bit word
    localparam int PPO_DEG_LSB = 14;
    localparam int PPO_OVERSHOOT_EN_BIT = 13;
    localparam int PPO_UNDERSHOOT_EN_BIT = 12;
    localparam int PPO_OVLD_FLAG_BIT = 11;
    localparam int PPO_RELAX_FLAG_BIT = 10;
    localparam int PPO_CYC_LSB = 8;
    localparam int PPO_EXT_LIMIT_BIT = 7;
    localparam int PPO_MON_DIR_BIT = 6;
    localparam int PPO_LOW_SW_BIT = 5;
    localparam int PPO_IN_SENSE_BIT = 4;
    localparam int PPO_IN_OC_EN_BIT = 3;
    localparam int PPO_IN_OC_LVL_BIT = 2;
    localparam int PPO_CELL_EN_BIT = 1;
    localparam int PPO_CELL_LVL_BIT = 0;

    // Timing
    localparam longint PPO_CLK_HZ = 50000000;
    localparam longint PPO_MS_CYCLES = (PPO_CLK_HZ + 999) / 1000;
    localparam longint PPO_BLANK_US = 100;
    localparam longint PPO_BLANK_CYCLES = (PPO_BLANK_US * PPO_CLK_HZ + 999999) / 1000000;
    localparam int PPO_PRE_W = 32;

    // Deglitch and cycle times in ms, indexed by code
    localparam logic [7:0] PPO_DEG_MS [4] = '{8'h01, 8'h02, 8'h0a, 8'h14};
    localparam logic [7:0] PPO_CYC_MS [4] = '{8'h05, 8'h0a, 8'h14, 8'h28};

    // Threshold values
    localparam logic [8:0] PPO_LOW_SW_MV_0 = 9'h0d2;
    localparam logic [8:0] PPO_LOW_SW_MV_1 = 9'h096;
    localparam logic [8:0] PPO_IN_SENSE_MV_0 = 9'h118;
    localparam logic [8:0] PPO_IN_SENSE_MV_1 = 9'h096;
    localparam logic [7:0] PPO_IN_OC_PCT_0 = 8'h7d;
    localparam logic [7:0] PPO_IN_OC_PCT_1 = 8'hd2;
    localparam logic [7:0] PPO_CELL_PCT_0 = 8'h7d;
    localparam logic [7:0] PPO_CELL_PCT_1 = 8'hc8;

    // Peak power cycle states, Gray along idle-qualify-overload-relax
    typedef enum logic [1:0] {
        PPO_IDLE = 2'b00,
        PPO_QUAL = 2'b01,
        PPO_OVLD = 2'b11,
        PPO_RELAX = 2'b10
    } ppo_state_t;

endpackage

// file: ppo_reg_if.sv
// Interface between the register file and the control logic.
// Assumes both ends share sys_clk.
`timescale 1ns/1ps
interface ppo_reg_if;
    logic [15:0] cfg;
    logic ovldFlag;
    logic relaxFlag;
    logic clrOvld;
    logic clrRelax;
    logic adapterGone;

    modport regs (output cfg, output clrOvld, output clrRelax, input ovldFlag, input relaxFlag, input adapterGone);
    modport ctrl (input cfg, input clrOvld, input clrRelax, output ovldFlag, output relaxFlag, output adapterGone);
endinterface

// file: ppo_persist.sv
// Counts how long a level has been held and flags when a limit is reached.
// Assumes the level is synchronous to sys_clk.
`timescale 1ns/1ps
module ppo_persist #(
    parameter longint LIMIT = 16
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic level,
    output logic done_q
);
    import ppo_pkg::*;

    localparam logic [PPO_PRE_W-1:0] LAST = PPO_PRE_W'(LIMIT - 1);

    logic [PPO_PRE_W-1:0] count_q;
    logic [PPO_PRE_W-1:0] count_d;
    wire atLast = (count_q >= LAST);

    assign count_d = !level ? '0 : (atLast ? count_q : count_q + 1'b1);

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            count_q <= '0;
            done_q <= 1'b0;
        end else begin
            count_q <= count_d;
            done_q <= level && atLast;
        end
    end
endmodule

// file: ppo_regfile.sv
// Two-byte register pair holding the options word, byte access by index.
// Assumes the register port is driven synchronously by the host agent.
`timescale 1ns/1ps
module ppo_regfile (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic wrEn,
    input wire logic rdEn,
    input wire logic [7:0] index,
    input wire logic [7:0] wrData,
    output logic [7:0] rdData_q,
    output logic rdValid_q,
    ppo_reg_if.regs rif
);
    import ppo_pkg::*;

    logic [15:0] cfg_q;
    logic [15:0] cfg_d;
    logic clrOvld_q;
    logic clrRelax_q;

    wire hitHigh = (index == PPO_IDX_HIGH);
    wire hitLow = (index == PPO_IDX_LOW);
    wire wrHigh = wrEn && hitHigh;
    wire wrLow = wrEn && hitLow;
    wire [15:0] liveWord = {cfg_q[15:12], rif.ovldFlag, rif.relaxFlag, cfg_q[9:0]};
    wire [7:0] rdSel = hitHigh ? liveWord[15:8] : (hitLow ? liveWord[7:0] : 8'h00);

    wire [15:0] written = {wrHigh ? wrData : cfg_q[15:8], wrLow ? wrData : cfg_q[7:0]};
    wire [1:0] trigBits = rif.adapterGone ? 2'b00 : written[13:12];
    assign cfg_d = {written[15:14], trigBits, 2'b00, written[9:0]};

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cfg_q <= PPO_RESET;
            rdData_q <= 8'h00;
            rdValid_q <= 1'b0;
            clrOvld_q <= 1'b0;
            clrRelax_q <= 1'b0;
        end else begin
            cfg_q <= cfg_d;
            rdData_q <= rdEn ? rdSel : rdData_q;
            rdValid_q <= rdEn;
            clrOvld_q <= wrHigh && !wrData[PPO_OVLD_FLAG_BIT-8];
            clrRelax_q <= wrHigh && !wrData[PPO_RELAX_FLAG_BIT-8];
        end
    end

    assign rif.cfg = cfg_q;
    assign rif.clrOvld = clrOvld_q;
    assign rif.clrRelax = clrRelax_q;
endmodule

// file: ppo_top.sv
// Peak power and overcurrent options: register pair, peak power cycle
// sequencer, overcurrent shutdown latch and derived thresholds.
// Assumes an external serial agent turns bus traffic into byte reads and
// writes by register index, and all analog inputs are synchronous levels.
//
// Behaviour
// - Upper byte index 33h, lower 32h
// - Deglitch code selects 1/2/10/20 ms
// - Bit 5 enables overshoot trigger
// - Bit 4 enables undershoot trigger
// - Both enables zero disables peak power
// - Adapter removal clears both trigger enables
// - Overload flag; writing zero leaves cycle
// - Relax flag; writing zero leaves cycle
// - Cycle code selects 5/10/20/40 ms
// - Deglitch longer than cycle: no relax
// - Limit source: register or lower of both
// - Monitor shows discharge or charge current
// - Low switch trip 210 or 150 mV
// - Input sense trip 280 or 150 mV
// - Blanked input overcurrent disables converter
// - Input overcurrent level 125 or 210 percent
// - Cell discharge overcurrent disables converter
// - Cell discharge level 125 or 200 percent
`timescale 1ns/1ps
module ppo_top #(
    parameter longint MS_CYCLES = ppo_pkg::PPO_MS_CYCLES,
    parameter longint BLANK_CYCLES = ppo_pkg::PPO_BLANK_CYCLES
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [7:0] regIndex,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData_q,
    output logic regRdValid_q,
    input wire logic adapterRemoved,
    input wire logic inputOvershoot,
    input wire logic railUndershoot,
    input wire logic inputOvercurrent,
    input wire logic cellDischargeOvercurrent,
    input wire logic converterRestart,
    input wire logic [7:0] limitSettingPin,
    input wire logic [7:0] limitRegister,
    input wire logic [7:0] chargeCurrent,
    input wire logic [7:0] dischargeCurrent,
    output logic [7:0] inputLimit_q,
    output logic [7:0] cellCurrentMonitor_q,
    output logic [8:0] lowSwitchTripMv_q,
    output logic [8:0] inputSenseTripMv_q,
    output logic [7:0] inputOvercurrentPct_q,
    output logic [7:0] cellDischargePct_q,
    output logic inputOvercurrentArmed_q,
    output logic cellDischargeArmed_q,
    output logic peakPowerEnabled_q,
    output logic overloadActive_q,
    output logic relaxActive_q,
    output logic converterDisable_q
);
    import ppo_pkg::*;

    localparam logic [PPO_PRE_W-1:0] MS_LAST = PPO_PRE_W'(MS_CYCLES - 1);

    ppo_reg_if rif();

    ppo_regfile u_regs (
        .sys_clk(sys_clk),
        .reset(reset),
        .wrEn(regWrEn),
        .rdEn(regRdEn),
        .index(regIndex),
        .wrData(regWrData),
        .rdData_q(regRdData_q),
        .rdValid_q(regRdValid_q),
        .rif(rif)
    );

    // Field decode
    wire [1:0] deglitchCode = rif.cfg[PPO_DEG_LSB +: 2];
    wire [1:0] cycleCode = rif.cfg[PPO_CYC_LSB +: 2];
    wire overshootEn = rif.cfg[PPO_OVERSHOOT_EN_BIT];
    wire undershootEn = rif.cfg[PPO_UNDERSHOOT_EN_BIT];
    wire extLimitSel = rif.cfg[PPO_EXT_LIMIT_BIT];
    wire monitorDirSel = rif.cfg[PPO_MON_DIR_BIT];
    wire lowSwitchSel = rif.cfg[PPO_LOW_SW_BIT];
    wire inputSenseSel = rif.cfg[PPO_IN_SENSE_BIT];
    wire inputOcEn = rif.cfg[PPO_IN_OC_EN_BIT];
    wire inputOcLevelSel = rif.cfg[PPO_IN_OC_LVL_BIT];
    wire cellTripEn = rif.cfg[PPO_CELL_EN_BIT];
    wire cellTripLevelSel = rif.cfg[PPO_CELL_LVL_BIT];

    assign rif.adapterGone = adapterRemoved;

    wire [7:0] deglitchMs = PPO_DEG_MS[deglitchCode];
    wire [7:0] cycleMs = PPO_CYC_MS[cycleCode];
    // Relax skipped when deglitch is longer
    wire skipRelax = (deglitchMs > cycleMs);

    // Peak power needs at least one trigger enable
    wire peakEnabled = overshootEn || undershootEn;
    wire overshootTrig = overshootEn && inputOvershoot;
    wire undershootTrig = undershootEn && railUndershoot;
    wire surgeTrig = peakEnabled && (overshootTrig || undershootTrig);

    // Peak power cycle sequencer
    ppo_state_t state_q;
    ppo_state_t state_d;
    logic [PPO_PRE_W-1:0] preCount_q;
    logic [PPO_PRE_W-1:0] preCount_d;
    logic [7:0] msCount_q;
    logic [7:0] msCount_d;

    wire msTick = (preCount_q >= MS_LAST);
    wire deglitchDone = (msCount_q >= deglitchMs);
    wire cycleDone = (msCount_q >= cycleMs);

    always_comb begin
        state_d = state_q;
        case (state_q)
            PPO_IDLE: begin
                if (surgeTrig) begin
                    state_d = PPO_QUAL;
                end
            end
            PPO_QUAL: begin
                if (!surgeTrig) begin
                    state_d = PPO_IDLE;
                end else if (deglitchDone) begin
                    state_d = PPO_OVLD;
                end
            end
            PPO_OVLD: begin
                if (rif.clrOvld || !peakEnabled) begin
                    state_d = PPO_IDLE;
                end else if (cycleDone) begin
                    // Go straight back when relax is skipped
                    state_d = skipRelax ? PPO_IDLE : PPO_RELAX;
                end
            end
            PPO_RELAX: begin
                if (rif.clrRelax || !peakEnabled) begin
                    state_d = PPO_IDLE;
                end else if (cycleDone) begin
                    state_d = PPO_IDLE;
                end
            end
            default: begin
                state_d = PPO_IDLE;
            end
        endcase
    end

    // Time base restarts on every state change
    wire stateChange = (state_d != state_q);
    assign preCount_d = (stateChange || msTick) ? '0 : preCount_q + 1'b1;

    always_comb begin
        msCount_d = msCount_q;
        if (stateChange) begin
            msCount_d = 8'h00;
        end else if (msTick && msCount_q != 8'hff) begin
            msCount_d = msCount_q + 8'h01;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_q <= PPO_IDLE;
            preCount_q <= '0;
            msCount_q <= 8'h00;
        end else begin
            state_q <= state_d;
            preCount_q <= preCount_d;
            msCount_q <= msCount_d;
        end
    end

    wire inOverload_d = (state_d == PPO_OVLD);
    wire inRelax_d = (state_d == PPO_RELAX);

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            overloadActive_q <= 1'b0;
            relaxActive_q <= 1'b0;
            peakPowerEnabled_q <= 1'b0;
        end else begin
            overloadActive_q <= inOverload_d;
            relaxActive_q <= inRelax_d;
            peakPowerEnabled_q <= peakEnabled;
        end
    end

    assign rif.ovldFlag = overloadActive_q;
    assign rif.relaxFlag = relaxActive_q;

    // Overcurrent shutdown
    logic inputOcBlanked;

    ppo_persist #(
        .LIMIT(BLANK_CYCLES)
    ) u_blank (
        .sys_clk(sys_clk),
        .reset(reset),
        .level(inputOvercurrent && inputOcEn),
        .done_q(inputOcBlanked)
    );

    // Cell discharge trip acts at once
    wire cellTrip = cellTripEn && cellDischargeOvercurrent;
    wire inputTrip = inputOcBlanked && inputOcEn;
    // Latched off until restarted; a new trip wins over the restart
    wire converterDisable_d = inputTrip || cellTrip || (converterDisable_q && !converterRestart);

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            converterDisable_q <= 1'b0;
        end else begin
            converterDisable_q <= converterDisable_d;
        end
    end

    wire [7:0] lowerLimit = (limitSettingPin < limitRegister) ? limitSettingPin : limitRegister;
    wire [7:0] inputLimit_d = extLimitSel ? lowerLimit : limitRegister;
    wire [7:0] monitor_d = monitorDirSel ? chargeCurrent : dischargeCurrent;
    wire [8:0] lowSwitch_d = lowSwitchSel ? PPO_LOW_SW_MV_1 : PPO_LOW_SW_MV_0;
    wire [8:0] inputSense_d = inputSenseSel ? PPO_IN_SENSE_MV_1 : PPO_IN_SENSE_MV_0;
    wire [7:0] inputOcPct_d = inputOcLevelSel ? PPO_IN_OC_PCT_1 : PPO_IN_OC_PCT_0;
    wire [7:0] cellPct_d = cellTripLevelSel ? PPO_CELL_PCT_1 : PPO_CELL_PCT_0;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            inputLimit_q <= 8'h00;
            cellCurrentMonitor_q <= 8'h00;
            lowSwitchTripMv_q <= PPO_LOW_SW_MV_1;
            inputSenseTripMv_q <= PPO_IN_SENSE_MV_1;
            inputOvercurrentPct_q <= PPO_IN_OC_PCT_1;
            cellDischargePct_q <= PPO_CELL_PCT_1;
            inputOvercurrentArmed_q <= 1'b0;
            cellDischargeArmed_q <= 1'b1;
        end else begin
            inputLimit_q <= inputLimit_d;
            cellCurrentMonitor_q <= monitor_d;
            lowSwitchTripMv_q <= lowSwitch_d;
            inputSenseTripMv_q <= inputSense_d;
            inputOvercurrentPct_q <= inputOcPct_d;
            cellDischargePct_q <= cellPct_d;
            inputOvercurrentArmed_q <= inputOcEn;
            cellDischargeArmed_q <= cellTripEn;
        end
    end
endmodule

// file: ppo_monitor.sv
// Concurrent checks on the ppo_top ports.
// Assumes it is bound into ppo_top and sees only its ports.
`timescale 1ns/1ps
module ppo_monitor #(
    parameter longint BLANK_CYCLES = 8
) (
    input logic sys_clk,
    input logic reset,
    input logic regWrEn,
    input logic regRdEn,
    input logic [7:0] regIndex,
    input logic [7:0] regWrData,
    input logic [7:0] regRdData_q,
    input logic regRdValid_q,
    input logic adapterRemoved,
    input logic inputOvercurrent,
    input logic cellDischargeOvercurrent,
    input logic [8:0] lowSwitchTripMv_q,
    input logic [7:0] cellDischargePct_q,
    input logic cellDischargeArmed_q,
    input logic peakPowerEnabled_q,
    input logic overloadActive_q,
    input logic relaxActive_q,
    input logic converterDisable_q
);
    logic [7:0] wrLow_q;
    logic [15:0] ocCnt_q;
    wire logic wrLow = regWrEn && regIndex == 8'h32;
    // Last lower byte written and length of the present input overcurrent
    always_ff @(posedge sys_clk) begin
        if (wrLow) begin
            wrLow_q <= regWrData;
        end
        if (reset || !inputOvercurrent) begin
            ocCnt_q <= 16'h0000;
        end else if (ocCnt_q != 16'hffff) begin
            ocCnt_q <= ocCnt_q + 16'h0001;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    rd_valid_a: assert property (regRdEn |=> regRdValid_q) else $error("read not answered");
    rd_unmap_a: assert property (regRdEn && regIndex != 8'h32 && regIndex != 8'h33 |=> regRdData_q == 8'h00)
        else $error("unmapped read not zero");
    peak_off_a: assert property (regWrEn && regIndex == 8'h33 && regWrData[5:4] == 2'b00 |=> ##1 !peakPowerEnabled_q)
        else $error("peak power on without trigger enables");
    adapter_clear_a: assert property (adapterRemoved |=> ##1 !peakPowerEnabled_q)
        else $error("adapter removal left peak power on");
    low_trip_a: assert property (wrLow ##1 !wrLow |=> lowSwitchTripMv_q == (wrLow_q[5] ? 9'h096 : 9'h0d2))
        else $error("low switch trip level wrong");
    cell_pct_a: assert property (wrLow ##1 !wrLow |=> cellDischargePct_q == (wrLow_q[0] ? 8'hc8 : 8'h7d))
        else $error("cell discharge level wrong");
    cell_trip_a: assert property (cellDischargeOvercurrent ##1 cellDischargeArmed_q |-> converterDisable_q)
        else $error("cell overcurrent did not stop converter");
    oc_blank_a: assert property ($rose(converterDisable_q) && !$past(cellDischargeOvercurrent) |-> ocCnt_q >= BLANK_CYCLES)
        else $error("input overcurrent tripped before blanking");
    ovld_clear_a: assert property (regWrEn && regIndex == 8'h33 && !regWrData[3] && overloadActive_q
        |-> ##[1:5] !overloadActive_q) else $error("overload not left after clear");
    flag_excl_a: assert property (!(overloadActive_q && relaxActive_q)) else $error("both cycle flags set");
    cover property ($rose(overloadActive_q));
    cover property ($rose(relaxActive_q));
    cover property ($rose(converterDisable_q));
endmodule

bind ppo_top ppo_monitor #(.BLANK_CYCLES(BLANK_CYCLES)) i_mon (.sys_clk(sys_clk), .reset(reset), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regIndex(regIndex), .regWrData(regWrData), .regRdData_q(regRdData_q),
    .regRdValid_q(regRdValid_q), .adapterRemoved(adapterRemoved), .inputOvercurrent(inputOvercurrent),
    .cellDischargeOvercurrent(cellDischargeOvercurrent), .lowSwitchTripMv_q(lowSwitchTripMv_q),
    .cellDischargePct_q(cellDischargePct_q), .cellDischargeArmed_q(cellDischargeArmed_q),
    .peakPowerEnabled_q(peakPowerEnabled_q), .overloadActive_q(overloadActive_q), .relaxActive_q(relaxActive_q),
    .converterDisable_q(converterDisable_q));

// file: ppo_host.sv
// Host agent: byte register writes and reads by index.
// Assumes callers start 1 ns after a sys_clk edge.
`timescale 1ns/1ps
module ppo_host (
    input wire logic sys_clk,
    output logic regWrEn,
    output logic regRdEn,
    output logic [7:0] regIndex,
    output logic [7:0] regWrData
);
    initial begin
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regIndex = 8'h00;
        regWrData = 8'h00;
    end
    // Released lines show the inverse, then one idle cycle
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        regIndex = idx;
        regWrData = d;
        regWrEn = 1'b1;
        @(posedge sys_clk);
        #1;
        regWrEn = 1'b0;
        regIndex = ~idx;
        regWrData = ~d;
        @(posedge sys_clk);
        #1;
    endtask
    task automatic rd(input logic [7:0] idx);
        regIndex = idx;
        regRdEn = 1'b1;
        @(posedge sys_clk);
        #1;
        regRdEn = 1'b0;
        regIndex = ~idx;
        @(posedge sys_clk);
        #1;
    endtask
endmodule

// file: peak_power_overcurrent_config_tb.sv
// Testbench for ppo_top with shortened millisecond and blanking counts.
// Assumes ppo_host and the bound ppo_monitor are compiled alongside.
`timescale 1ns/1ps
module peak_power_overcurrent_config_tb;
    logic sys_clk, reset, regWrEn, regRdEn, regRdValid_q, adapterRemoved, inputOvershoot, railUndershoot;
    logic inputOvercurrent, cellDischargeOvercurrent, converterRestart, inputOvercurrentArmed_q, cellDischargeArmed_q;
    logic peakPowerEnabled_q, overloadActive_q, relaxActive_q, converterDisable_q;
    logic [7:0] regIndex, regWrData, regRdData_q, limitSettingPin, limitRegister, chargeCurrent, dischargeCurrent;
    logic [7:0] inputLimit_q, cellCurrentMonitor_q, inputOvercurrentPct_q, cellDischargePct_q, d;
    logic [8:0] lowSwitchTripMv_q, inputSenseTripMv_q;
    logic [7:0] expQ[$];
    logic [7:0] codes[3] = '{8'h61, 8'ha2, 8'h23};
    int degMs[3] = '{2, 10, 1}, cycMs[3] = '{10, 20, 40};
    int badCount = 0, cmpCount = 0, cycCount = 0, seed = 50811, t;
    ppo_host i_host (.sys_clk(sys_clk), .regWrEn(regWrEn), .regRdEn(regRdEn), .regIndex(regIndex),
        .regWrData(regWrData));
    ppo_top #(.MS_CYCLES(10), .BLANK_CYCLES(8)) i_dut (.sys_clk(sys_clk), .reset(reset), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regIndex(regIndex), .regWrData(regWrData), .regRdData_q(regRdData_q),
        .regRdValid_q(regRdValid_q), .adapterRemoved(adapterRemoved), .inputOvershoot(inputOvershoot),
        .railUndershoot(railUndershoot), .inputOvercurrent(inputOvercurrent),
        .cellDischargeOvercurrent(cellDischargeOvercurrent), .converterRestart(converterRestart),
        .limitSettingPin(limitSettingPin), .limitRegister(limitRegister), .chargeCurrent(chargeCurrent),
        .dischargeCurrent(dischargeCurrent), .inputLimit_q(inputLimit_q), .cellCurrentMonitor_q(cellCurrentMonitor_q),
        .lowSwitchTripMv_q(lowSwitchTripMv_q), .inputSenseTripMv_q(inputSenseTripMv_q),
        .inputOvercurrentPct_q(inputOvercurrentPct_q), .cellDischargePct_q(cellDischargePct_q),
        .inputOvercurrentArmed_q(inputOvercurrentArmed_q), .cellDischargeArmed_q(cellDischargeArmed_q),
        .peakPowerEnabled_q(peakPowerEnabled_q), .overloadActive_q(overloadActive_q),
        .relaxActive_q(relaxActive_q), .converterDisable_q(converterDisable_q));
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmpCount, badCount);
        if (badCount == 0 && cmpCount > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input string n, input logic [15:0] s, input logic [15:0] x);
        cmpCount++;
        if (s !== x) begin
            badCount++;
            $display("mismatch %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic rd(input logic [7:0] i, input logic [7:0] x);
        expQ.push_back(x);
        i_host.rd(i);
    endtask
    // Bounded wait on a cycle flag, t holds the cycles spent
    task automatic waitv(input int s, input logic v, input int lim);
        t = 0;
        while ((s == 0 ? overloadActive_q : relaxActive_q) !== v && t < lim) begin
            tick(1);
            t++;
        end
    endtask
    task automatic chkLow(input logic [7:0] v);
        check("lowTrip", lowSwitchTripMv_q, v[5] ? 9'h096 : 9'h0d2);
        check("senseTrip", inputSenseTripMv_q, v[4] ? 9'h096 : 9'h118);
        check("inPct", inputOvercurrentPct_q, v[2] ? 8'hd2 : 8'h7d);
        check("cellPct", cellDischargePct_q, v[0] ? 8'hc8 : 8'h7d);
        check("armed", {inputOvercurrentArmed_q, cellDischargeArmed_q}, {v[3], v[1]});
        check("limit", inputLimit_q, (v[7] && limitSettingPin < limitRegister) ? limitSettingPin : limitRegister);
        check("monitor", cellCurrentMonitor_q, v[6] ? chargeCurrent : dischargeCurrent);
    endtask
    // Read results are matched against the oldest note
    always @(negedge sys_clk) begin
        if (regRdValid_q === 1'b1) begin
            if (expQ.size() == 0) begin
                check("rdExtra", 16'h0001, 16'h0000);
            end else begin
                check("rdData", regRdData_q, expQ.pop_front());
            end
        end
    end
    always @(posedge sys_clk) begin
        cycCount++;
        if (cycCount == 4000) begin
            badCount++;
            finish_test();
        end
    end
    initial begin
        reset = 1'b1;
        {adapterRemoved, inputOvershoot, railUndershoot, inputOvercurrent, cellDischargeOvercurrent} = 5'h00;
        converterRestart = 1'b0;
        {limitSettingPin, limitRegister, chargeCurrent, dischargeCurrent} = 32'h00000000;
        tick(5);
        reset = 1'b0;
        chkLow(8'hb7);
        rd(8'h32, 8'hb7);
        rd(8'h33, 8'h02);
        i_host.wr(8'h40, 8'hff);
        rd(8'h40, 8'h00);
        rd(8'h32, 8'hb7);
        for (int k = 0; k < 8; k++) begin
            d = 8'($random(seed));
            {limitSettingPin, limitRegister} = 16'($random(seed));
            {chargeCurrent, dischargeCurrent} = 16'($random(seed));
            i_host.wr(8'h32, d);
            rd(8'h32, d);
            chkLow(d);
        end
        // Flag bits are not stored; adapter removal drops the enables
        i_host.wr(8'h33, 8'h3e);
        rd(8'h33, 8'h32);
        check("peakOn", peakPowerEnabled_q, 1'b1);
        adapterRemoved = 1'b1;
        tick(1);
        adapterRemoved = 1'b0;
        rd(8'h33, 8'h02);
        check("peakGone", peakPowerEnabled_q, 1'b0);
        i_host.wr(8'h33, 8'h20);
        inputOvershoot = 1'b1;
        waitv(0, 1'b1, 40);
        check("qualTime", t >= 10 && t <= 16, 1'b1);
        rd(8'h33, 8'h28);
        waitv(1, 1'b1, 80);
        check("ovldTime", t >= 42 && t <= 52, 1'b1);
        check("ovldOff", overloadActive_q, 1'b0);
        rd(8'h33, 8'h24);
        waitv(1, 1'b0, 80);
        check("relaxTime", t >= 42 && t <= 52, 1'b1);
        waitv(0, 1'b1, 40);
        i_host.wr(8'h33, 8'h20);
        tick(2);
        check("ovldExit", {overloadActive_q, relaxActive_q}, 2'b00);
        inputOvershoot = 1'b0;
        railUndershoot = 1'b1;
        i_host.wr(8'h33, 8'h10);
        waitv(1, 1'b1, 120);
        check("relaxRail", relaxActive_q, 1'b1);
        i_host.wr(8'h33, 8'h10);
        tick(2);
        check("relaxExit", relaxActive_q, 1'b0);
        i_host.wr(8'h33, 8'hd0);
        waitv(0, 1'b1, 300);
        check("longQual", t >= 180 && t < 300, 1'b1);
        waitv(0, 1'b0, 80);
        tick(3);
        check("noRelax", relaxActive_q, 1'b0);
        i_host.wr(8'h33, 8'h00);
        inputOvershoot = 1'b1;
        tick(40);
        check("peakOff", {peakPowerEnabled_q, overloadActive_q}, 2'b00);
        // Remaining deglitch and cycle codes, each through overload and relax
        for (int k = 0; k < 3; k++) begin
            i_host.wr(8'h33, codes[k]);
            waitv(0, 1'b1, 120);
            check("degCode", t >= 10 * degMs[k] && t <= 10 * degMs[k] + 5, 1'b1);
            waitv(1, 1'b1, 420);
            check("cycCode", t >= 10 * cycMs[k] - 2 && t <= 10 * cycMs[k] + 2, 1'b1);
            waitv(1, 1'b0, 420);
            check("relaxCode", t >= 10 * cycMs[k] - 2 && t <= 10 * cycMs[k] + 2, 1'b1);
            i_host.wr(8'h33, 8'h00);
        end
        {inputOvershoot, railUndershoot} = 2'b00;
        i_host.wr(8'h32, 8'h0a);
        cellDischargeOvercurrent = 1'b1;
        tick(1);
        cellDischargeOvercurrent = 1'b0;
        tick(1);
        check("cellTrip", converterDisable_q, 1'b1);
        for (int k = 0; k < 3; k++) begin
            converterRestart = 1'b1;
            tick(1);
            converterRestart = 1'b0;
            tick(1);
            check("restart", converterDisable_q, 1'b0);
            if (k == 2) begin
                i_host.wr(8'h32, 8'h02);
            end
            inputOvercurrent = 1'b1;
            tick(k == 0 ? 6 : 12);
            check("inputTrip", converterDisable_q, k == 1);
            inputOvercurrent = 1'b0;
            tick(2);
        end
        check("queue", 16'(expQ.size()), 16'h0000);
        finish_test();
    end
endmodule
